//--- bench/rpdc_partner.sv
// system controller and clock source model facing the power pin
`timescale 1ns/1ps
`default_nettype none
module rpdc_partner #(
   parameter int LOCK_CYC = 6
) (
   input wire logic core_clk,
   input wire logic pwr_good,
   input wire logic pd_req,
   input wire logic osc_enable,
   output logic pg_pd_pin,
   output logic synth_clk_in,
   output logic pll_locked
);
   int lock_cnt = 0;
   initial begin
      pg_pd_pin = 1'b0;
      synth_clk_in = 1'b0;
      pll_locked = 1'b0;
   end
   ////////////////////////////////////////////////////////////
   // pin is power-good first, then the active-low request
   always @(posedge core_clk) begin
      pg_pd_pin <= pwr_good & ~pd_req;
   end
   // synthesizer only runs while the oscillators are enabled
   always @(posedge core_clk) begin
      synth_clk_in <= osc_enable ? ~synth_clk_in : 1'b0;
   end
   // the loop only starts to lock once the pin reads high
   always @(posedge core_clk) begin
      lock_cnt <= (osc_enable && pg_pd_pin) ? lock_cnt + 1 : 0;
      pll_locked <= osc_enable && pg_pd_pin && lock_cnt >= LOCK_CYC;
   end
endmodule : rpdc_partner
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the power-down and configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [4:0] ID_VAL = 5'h0A; // arbitrary value
   localparam logic [7:0] WR = 8'hD2;
   localparam logic [7:0] RD = 8'hD3;
   logic core_clk = 1'b0;
   logic rst, pwr_good, pd_req, ref_div_in, scl, sda_m;
   logic pin, synth, locked, sda_out, sda_oe, osc_en;
   logic [3:0] outp, outn, oe;
   logic [2:0] swing;
   wire sda_wire = sda_m & ~sda_oe;
   int fails = 0;
   int checked = 0;
   logic [7:0] idx_tab [7] = '{8'h00, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
   logic [7:0] rst_tab [7] = '{8'h01, 8'h25, 8'h03, 8'h07, 8'h0F, 8'hFC,
      {rpdc_pkg::IDENT_FIXED_HI, ID_VAL}};
   always #50 core_clk = ~core_clk;
   rpdc_top #(.NUM_OUT(4), .DEV_ADDR(7'h69), .PROG_ID(ID_VAL), .PWRUP_CYC(20)) u_dut (
      .core_clk(core_clk), .rst(rst), .pg_pd_pin(pin), .synth_clk_in(synth),
      .ref_div_in(ref_div_in), .pll_locked(locked), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .ref_clock_out(outp), .ref_clock_out_n(outn),
      .ref_clock_oe(oe), .diff_swing_code(swing), .osc_enable(osc_en));
   rpdc_partner u_partner (.core_clk(core_clk), .pwr_good(pwr_good), .pd_req(pd_req),
      .osc_enable(osc_en), .pg_pd_pin(pin), .synth_clk_in(synth), .pll_locked(locked));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic half();
      repeat (3) @(posedge core_clk);
   endtask : half
   task automatic start_c();
      sda_m <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_m <= 1'b0;
      half();
      scl <= 1'b0;
   endtask : start_c
   task automatic stop_c();
      sda_m <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_m <= 1'b1;
      half();
   endtask : stop_c
   task automatic tx(input logic [7:0] b, input logic exp_ack);
      logic ack;
      for (int i = 7; i >= 0; i--) begin
         sda_m <= b[i];
         half();
         scl <= 1'b1;
         half();
         scl <= 1'b0;
      end
      sda_m <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      ack = ~sda_wire;
      scl <= 1'b0;
      chk({7'h0, ack}, {7'h0, exp_ack});
   endtask : tx
   task automatic rx(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--) begin
         sda_m <= 1'b1;
         half();
         scl <= 1'b1;
         half();
         b[i] = sda_wire;
         scl <= 1'b0;
      end
      sda_m <= last;
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
   endtask : rx
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      start_c();
      tx(WR, 1'b1);
      tx(idx, 1'b1);
      tx(8'h01, 1'b1);
      tx(data, 1'b1);
      stop_c();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] ecnt, input logic [7:0] edat);
      logic [7:0] cnt, d;
      start_c();
      tx(WR, 1'b1);
      tx(idx, 1'b1);
      start_c();
      tx(RD, 1'b1);
      rx(cnt, 1'b0);
      rx(d, 1'b1);
      stop_c();
      chk(cnt, ecnt);
      chk(d, edat);
   endtask : rd
   task automatic wait_outs(input logic [7:0] exp, input int max);
      int n;
      n = 0;
      while ({outp, outn} !== exp && n < max) begin
         @(posedge core_clk);
         n++;
      end
      chk({outp, outn}, exp);
   endtask : wait_outs
   task automatic pd_cycle();
      pd_req <= 1'b1;
      wait_outs(8'h00, 12);
      chk({7'h0, osc_en}, 8'h01);
      repeat (3) @(posedge core_clk);
      chk({7'h0, osc_en}, 8'h00);
      pd_req <= 1'b0;
      wait_outs(8'hFF, 8);
      wait_outs(8'hF0, 40);
   endtask : pd_cycle
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge core_clk);
      fails++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      pwr_good = 1'b0;
      pd_req = 1'b0;
      ref_div_in = 1'b0;
      scl = 1'b1;
      sda_m = 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk({4'h0, oe}, 8'h00);
      chk({7'h0, sda_out}, 8'h00);
      chk({5'h0, swing}, {5'h0, rpdc_pkg::SWING_RESET});
      for (int i = 0; i < 7; i++) rd(idx_tab[i], 8'h0F, rst_tab[i]);
      start_c();
      tx(8'hA0, 1'b0);
      stop_c();
      pwr_good <= 1'b1;
      wait_outs(8'hFF, 10);
      wait_outs(8'hF0, 40);
      wait_outs(8'h0F, 4);
      for (int c = 0; c < 8; c++) begin
         wr(8'h09, {5'b00100, 3'(c)});
         chk({5'h0, swing}, 8'(c));
      end
      ref_div_in <= 1'b1;
      wr(8'h09, 8'h2D);
      chk({4'h0, oe}, 8'h00);
      wr(8'h09, 8'h3D);
      chk({oe, outp}, 8'hFF);
      ref_div_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({4'h0, outp}, 8'h00);
      wr(8'h09, 8'h35);
      chk({4'h0, oe}, 8'h0F);
      wait_outs(8'hF0, 6);
      wait_outs(8'h0F, 6);
      wr(8'h09, 8'h22);
      rd(8'h10, 8'h0F, 8'hFF);
      wr(8'h0C, 8'h10);
      rd(8'h10, 8'h10, 8'h00);
      wr(8'h0A, 8'h55);
      rd(8'h0A, 8'h10, 8'h03);
      pd_cycle();
      rd(8'h09, 8'h10, 8'h22);
      wr(8'h00, 8'h00);
      pd_cycle();
      rd(8'h09, 8'h0F, 8'h25);
      chk({5'h0, swing}, 8'h05);
      rst <= 1'b1;
      pwr_good <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      pwr_good <= 1'b1;
      repeat (6) @(posedge core_clk);
      pd_req <= 1'b1;
      wait_outs(8'h00, 20);
      repeat (5) @(posedge core_clk);
      chk({7'h0, osc_en}, 8'h00);
      pd_req <= 1'b0;
      wait_outs(8'hF0, 60);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire

//--- pkg/rpdc_pkg.sv
// constants and types for the reference clock power-down and configuration block
`default_nettype none
package rpdc_pkg;
   // register byte indices on the serial bus
   localparam logic [7:0] OFS_RETAIN = 8'h00;
   localparam logic [7:0] OFS_TEST = 8'h09;
   localparam logic [7:0] OFS_RSV10 = 8'h0A;
   localparam logic [7:0] OFS_RSV11 = 8'h0B;
   localparam logic [7:0] OFS_BLEN = 8'h0C;
   localparam logic [7:0] OFS_RSV13 = 8'h0D;
   localparam logic [7:0] OFS_IDENT = 8'h0E;
   // field positions
   localparam int TEST_SEL_BIT = 4;
   localparam int TEST_ENTRY_BIT = 3;
   localparam int RETAIN_BIT = 0;
   // reset and fixed values
   localparam logic [2:0] TEST_FIXED_HI = 3'h1;
   localparam logic [2:0] SWING_RESET = 3'h5;
   localparam logic [7:0] BLEN_RESET = 8'h0F;
   localparam logic [7:0] RSV10_VAL = 8'h03;
   localparam logic [7:0] RSV11_VAL = 8'h07;
   localparam logic [7:0] RSV13_VAL = 8'hFC;
   localparam logic [2:0] IDENT_FIXED_HI = 3'h5;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [1:0] STOP_EDGES = 2'h2;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam real PWRUP_LAT_MS = 1.8;
   localparam int PWRUP_CYC = int'($floor(PWRUP_LAT_MS * 1.0e6 / CLK_PERIOD_NS));
   // power sequencer states
   typedef enum logic [2:0] {
      RPDC_WAIT_PG = 3'b000,
      RPDC_RAMP = 3'b001,
      RPDC_RUN = 3'b010,
      RPDC_STOP = 3'b011,
      RPDC_PD = 3'b100
   } rpdc_pwr_t;
   // serial slave states
   typedef enum logic [2:0] {
      RPDC_S_IDLE = 3'b000,
      RPDC_S_ADDR = 3'b001,
      RPDC_S_CMD = 3'b010,
      RPDC_S_WR = 3'b011,
      RPDC_S_RD = 3'b100
   } rpdc_ser_t;
endpackage : rpdc_pkg
`default_nettype wire

//--- rtl/rpdc_top.sv
// power-down sequencer, output control and upper configuration bytes
`timescale 1ns/1ps
`default_nettype none

module rpdc_top #(
   parameter int NUM_OUT = 4,
   parameter logic [6:0] DEV_ADDR = 7'h69,
   parameter logic [4:0] PROG_ID = 5'h0A, // arbitrary value
   parameter int PWRUP_CYC = rpdc_pkg::PWRUP_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pg_pd_pin,
   input wire logic synth_clk_in,
   input wire logic ref_div_in,
   input wire logic pll_locked,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [NUM_OUT-1:0] ref_clock_out,
   output logic [NUM_OUT-1:0] ref_clock_out_n,
   output logic [NUM_OUT-1:0] ref_clock_oe,
   output logic [2:0] diff_swing_code,
   output logic osc_enable
);
   localparam int CW = $clog2(PWRUP_CYC + 1);
   localparam logic [CW-1:0] PWRUP_LAST = CW'(PWRUP_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic test_sel;
   logic test_entry;
   logic [7:0] block_read_length;
   logic config_retain;
   logic wr_stb;
   logic [7:0] wr_idx;
   logic [7:0] wr_dat;
   logic cfg_clear;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         test_sel <= 1'b0;
         test_entry <= 1'b0;
         diff_swing_code <= rpdc_pkg::SWING_RESET;
         block_read_length <= rpdc_pkg::BLEN_RESET;
         config_retain <= 1'b1;
      end else if (cfg_clear) begin
         // power-down without retention returns the configuration, except the retain bit, to defaults
         test_sel <= 1'b0;
         test_entry <= 1'b0;
         diff_swing_code <= rpdc_pkg::SWING_RESET;
         block_read_length <= rpdc_pkg::BLEN_RESET;
      end else if (wr_stb) begin
         case (wr_idx)
            rpdc_pkg::OFS_RETAIN: config_retain <= wr_dat[rpdc_pkg::RETAIN_BIT];
            rpdc_pkg::OFS_TEST: begin
               test_sel <= wr_dat[rpdc_pkg::TEST_SEL_BIT];
               test_entry <= wr_dat[rpdc_pkg::TEST_ENTRY_BIT];
               diff_swing_code <= wr_dat[2:0];
            end
            rpdc_pkg::OFS_BLEN: block_read_length <= wr_dat;
            default: ;
         endcase
      end
   end

   logic [7:0] rd_byte;
   logic [7:0] rd_idx;

   always_comb begin
      rd_byte = 8'h00;
      case (rd_idx)
         rpdc_pkg::OFS_RETAIN: rd_byte[rpdc_pkg::RETAIN_BIT] = config_retain;
         rpdc_pkg::OFS_TEST: rd_byte = {rpdc_pkg::TEST_FIXED_HI, test_sel, test_entry,
                                        diff_swing_code};
         rpdc_pkg::OFS_RSV10: rd_byte = rpdc_pkg::RSV10_VAL;
         rpdc_pkg::OFS_RSV11: rd_byte = rpdc_pkg::RSV11_VAL;
         rpdc_pkg::OFS_BLEN: rd_byte = block_read_length;
         rpdc_pkg::OFS_RSV13: rd_byte = rpdc_pkg::RSV13_VAL;
         rpdc_pkg::OFS_IDENT: rd_byte = {rpdc_pkg::IDENT_FIXED_HI, PROG_ID};
         default: rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-wire serial slave, block write and block read with a count byte
   rpdc_pkg::rpdc_ser_t ser_st;
   logic scl_q;
   logic sda_q;
   logic [7:0] shreg;
   logic [7:0] txreg;
   logic [3:0] bitcnt;
   logic ack_slot;
   logic cnt_phase;
   logic [7:0] idx;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
   assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;
   assign rd_idx = idx;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ser_st <= rpdc_pkg::RPDC_S_IDLE;
         shreg <= 8'h00;
         txreg <= 8'h00;
         bitcnt <= 4'h0;
         ack_slot <= 1'b0;
         cnt_phase <= 1'b0;
         idx <= 8'h00;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         wr_stb <= 1'b0;
         wr_idx <= 8'h00;
         wr_dat <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (bus_start) begin
            ser_st <= rpdc_pkg::RPDC_S_ADDR;
            bitcnt <= 4'h0;
            ack_slot <= 1'b0;
            cnt_phase <= 1'b1;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            ser_st <= rpdc_pkg::RPDC_S_IDLE;
            sda_oe <= 1'b0;
         end else if (ser_st != rpdc_pkg::RPDC_S_IDLE) begin
            if (scl_rise && !ack_slot && bitcnt < rpdc_pkg::BITS_PER_BYTE) begin
               shreg <= {shreg[6:0], sda_in};
               bitcnt <= bitcnt + 4'h1;
            end else if (scl_rise && ack_slot && ser_st == rpdc_pkg::RPDC_S_RD && sda_in) begin
               // master nack ends the block read
               ser_st <= rpdc_pkg::RPDC_S_IDLE;
            end
            if (scl_fall) begin
               if (bitcnt == rpdc_pkg::ACK_SLOT && !ack_slot) begin
                  ack_slot <= 1'b1;
                  sda_oe <= ser_st != rpdc_pkg::RPDC_S_RD;
                  unique case (ser_st)
                     rpdc_pkg::RPDC_S_ADDR: begin
                        if (shreg[7:1] != DEV_ADDR) begin
                           ser_st <= rpdc_pkg::RPDC_S_IDLE;
                           sda_oe <= 1'b0;
                        end else if (shreg[0]) begin
                           ser_st <= rpdc_pkg::RPDC_S_RD;
                        end else begin
                           ser_st <= rpdc_pkg::RPDC_S_CMD;
                        end
                     end
                     rpdc_pkg::RPDC_S_CMD: begin
                        idx <= shreg;
                        ser_st <= rpdc_pkg::RPDC_S_WR;
                     end
                     rpdc_pkg::RPDC_S_WR: begin
                        if (cnt_phase) begin
                           cnt_phase <= 1'b0;
                        end else begin
                           wr_stb <= 1'b1;
                           wr_idx <= idx;
                           wr_dat <= shreg;
                           idx <= idx + 8'h01;
                        end
                     end
                     rpdc_pkg::RPDC_S_RD: ;
                     default: ser_st <= rpdc_pkg::RPDC_S_IDLE;
                  endcase
               end else if (ack_slot) begin
                  ack_slot <= 1'b0;
                  bitcnt <= 4'h0;
                  sda_oe <= 1'b0;
                  if (ser_st == rpdc_pkg::RPDC_S_RD) begin
                     // first byte is the count, then data up to the count limit
                     if (cnt_phase) begin
                        txreg <= block_read_length;
                        sda_oe <= ~block_read_length[7];
                        cnt_phase <= 1'b0;
                     end else if (idx <= block_read_length) begin
                        txreg <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        idx <= idx + 8'h01;
                     end else begin
                        txreg <= rpdc_pkg::IDLE_BYTE;
                     end
                  end
               end else if (ser_st == rpdc_pkg::RPDC_S_RD && bitcnt != 4'h0) begin
                  txreg <= {txreg[6:0], 1'b1};
                  sda_oe <= ~txreg[6];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-good / power-down sequencer
   rpdc_pkg::rpdc_pwr_t pw_st;
   logic pin_s1;
   logic pin_s2;
   logic synth_q;
   logic synth_prev;
   logic synth_rise;
   logic [1:0] edge_cnt;
   logic [CW-1:0] ramp_cnt;
   logic pd_settled;

   assign synth_rise = synth_q & ~synth_prev;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         synth_q <= 1'b0;
         synth_prev <= 1'b0;
      end else begin
         pin_s1 <= pg_pd_pin;
         pin_s2 <= pin_s1;
         synth_q <= synth_clk_in;
         synth_prev <= synth_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pw_st <= rpdc_pkg::RPDC_WAIT_PG;
         edge_cnt <= 2'h0;
         ramp_cnt <= '0;
         cfg_clear <= 1'b0;
      end else begin
         cfg_clear <= 1'b0;
         unique case (pw_st)
            rpdc_pkg::RPDC_WAIT_PG: begin
               // pin reads as power-good until seen high
               if (pin_s2) begin
                  pw_st <= rpdc_pkg::RPDC_RAMP;
                  ramp_cnt <= '0;
               end
            end
            rpdc_pkg::RPDC_RAMP: begin
               if (!pin_s2) begin
                  pw_st <= rpdc_pkg::RPDC_PD;
                  cfg_clear <= ~config_retain;
               end else if (pll_locked || ramp_cnt == PWRUP_LAST) begin
                  pw_st <= rpdc_pkg::RPDC_RUN;
               end else begin
                  ramp_cnt <= ramp_cnt + CW'(1);
               end
            end
            rpdc_pkg::RPDC_RUN: begin
               if (!pin_s2) begin
                  pw_st <= rpdc_pkg::RPDC_STOP;
                  edge_cnt <= 2'h0;
               end
            end
            rpdc_pkg::RPDC_STOP: begin
               if (pin_s2) begin
                  pw_st <= rpdc_pkg::RPDC_RUN;
               end else if (synth_rise) begin
                  if (edge_cnt + 2'h1 == rpdc_pkg::STOP_EDGES) begin
                     pw_st <= rpdc_pkg::RPDC_PD;
                     cfg_clear <= ~config_retain;
                  end
                  edge_cnt <= edge_cnt + 2'h1;
               end
            end
            rpdc_pkg::RPDC_PD: begin
               if (pin_s2) begin
                  pw_st <= rpdc_pkg::RPDC_RAMP;
                  ramp_cnt <= '0;
               end
            end
            default: pw_st <= rpdc_pkg::RPDC_WAIT_PG;
         endcase
      end
   end

   // oscillators stop only after the drivers have sat low for a cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pd_settled <= 1'b0;
         osc_enable <= 1'b1;
      end else begin
         pd_settled <= pw_st == rpdc_pkg::RPDC_PD;
         osc_enable <= ~(pw_st == rpdc_pkg::RPDC_PD && pd_settled);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // differential output drivers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_clock_out <= '0;
         ref_clock_out_n <= '0;
         ref_clock_oe <= '0;
      end else begin
         unique case (pw_st)
            rpdc_pkg::RPDC_WAIT_PG: begin
               ref_clock_out <= '0;
               ref_clock_out_n <= '0;
               ref_clock_oe <= '0;
            end
            rpdc_pkg::RPDC_RAMP: begin
               ref_clock_out <= '1;
               ref_clock_out_n <= '1;
               ref_clock_oe <= '1;
            end
            rpdc_pkg::RPDC_PD: begin
               ref_clock_out <= '0;
               ref_clock_out_n <= '0;
               ref_clock_oe <= '1;
            end
            default: begin
               if (test_entry && !test_sel) begin
                  ref_clock_out <= '0;
                  ref_clock_out_n <= '0;
                  ref_clock_oe <= '0;
               end else if (test_entry) begin
                  ref_clock_out <= {NUM_OUT{ref_div_in}};
                  ref_clock_out_n <= {NUM_OUT{~ref_div_in}};
                  ref_clock_oe <= '1;
               end else begin
                  ref_clock_out <= {NUM_OUT{synth_q}};
                  ref_clock_out_n <= {NUM_OUT{~synth_q}};
                  ref_clock_oe <= '1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_last_stop_edge;
      pw_st == rpdc_pkg::RPDC_STOP && !pin_s2 && synth_rise && edge_cnt == 2'h1;
   endsequence
   sequence s_held_low;
      pw_st == rpdc_pkg::RPDC_PD ##1 (ref_clock_out == '0 && ref_clock_out_n == '0);
   endsequence

   property p_test_refdiv;
      pw_st == rpdc_pkg::RPDC_RUN && test_entry && test_sel && !cfg_clear
         |=> ref_clock_out == {NUM_OUT{$past(ref_div_in)}} && ref_clock_oe == '1;
   endproperty
   a_test_refdiv: assert property (p_test_refdiv) else $error("ref/N not driven");

   property p_normal_enabled;
      pw_st == rpdc_pkg::RPDC_RUN && !test_entry
         |=> ref_clock_oe == '1 && ref_clock_out == {NUM_OUT{$past(synth_q)}};
   endproperty
   a_normal_enabled: assert property (p_normal_enabled) else $error("normal output wrong");

   property p_count_write;
      wr_stb && wr_idx == rpdc_pkg::OFS_BLEN && !cfg_clear |=> block_read_length == $past(wr_dat);
   endproperty
   a_count_write: assert property (p_count_write) else $error("byte count not stored");

   property p_pg_hold;
      pw_st == rpdc_pkg::RPDC_WAIT_PG && !pin_s2 |=> pw_st == rpdc_pkg::RPDC_WAIT_PG;
   endproperty
   a_pg_hold: assert property (p_pg_hold) else $error("left power-good wait early");

   property p_sync_stop;
      pw_st == rpdc_pkg::RPDC_RUN
         |=> pw_st == ($past(pin_s2) ? rpdc_pkg::RPDC_RUN : rpdc_pkg::RPDC_STOP);
   endproperty
   a_sync_stop: assert property (p_sync_stop) else $error("request not acted on");

   property p_two_edges;
      s_last_stop_edge |=> s_held_low;
   endproperty
   a_two_edges: assert property (p_two_edges) else $error("clocks not held low");

   property p_osc_after_low;
      $fell(osc_enable) |-> ref_clock_out == '0 && $past(ref_clock_out) == '0;
   endproperty
   a_osc_after_low: assert property (p_osc_after_low) else $error("osc off before low");

   property p_pd_low;
      pw_st == rpdc_pkg::RPDC_PD |=> ref_clock_out == '0 && ref_clock_out_n == '0;
   endproperty
   a_pd_low: assert property (p_pd_low) else $error("outputs not low in power-down");

   property p_wake_high;
      pw_st == rpdc_pkg::RPDC_PD && pin_s2
         |=> pw_st == rpdc_pkg::RPDC_RAMP ##1 (ref_clock_out == '1 && ref_clock_out_n == '1);
   endproperty
   a_wake_high: assert property (p_wake_high) else $error("outputs not driven high");

   property p_lock_run;
      pw_st == rpdc_pkg::RPDC_RAMP && pin_s2 && pll_locked |=> pw_st == rpdc_pkg::RPDC_RUN;
   endproperty
   a_lock_run: assert property (p_lock_run) else $error("no enable after lock");

   property p_clear_cfg;
      cfg_clear |=> !test_entry && diff_swing_code == rpdc_pkg::SWING_RESET;
   endproperty
   a_clear_cfg: assert property (p_clear_cfg) else $error("config not cleared");

endmodule : rpdc_top

`default_nettype wire
